// [core/adccc_pkg.sv]
// package: register map, field positions, reset values, timing counts
// assumes an 8-bit special-register bus from the cpu core
package adccc_pkg;
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;
    localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'hE8;
    localparam logic [7:0] ADDR_WINDOW_LOWER      = 8'hC4;
    localparam logic [7:0] ADDR_WINDOW_UPPER      = 8'hC6;
    localparam logic [7:0] ADDR_RESULT            = 8'hBE;
    localparam logic [7:0] RST_CONVERTER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_REFERENCE_CONTROL  = 8'h00;
    localparam logic [7:0] RST_WINDOW_LOWER       = 8'hFF;
    localparam logic [7:0] RST_WINDOW_UPPER       = 8'h00;
    localparam logic [7:0] REF_WRITE_MASK         = 8'h0E;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_TRACK  = 6;
    localparam int BIT_DONE   = 5;
    localparam int BIT_START  = 4;
    localparam int BIT_WINDOW = 3;
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_TIMER0   = 3'h1;
    localparam logic [2:0] SRC_TIMER2   = 3'h2;
    localparam logic [2:0] SRC_TIMER1   = 3'h3;
    localparam logic [3:0] TRACK_CLOCKS = 4'h3;
    localparam logic [3:0] CONV_CLOCKS  = 4'h8;
    localparam logic [3:0] SAR_DIV      = 4'h4;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV  = 2'b10
    } adccc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adccc_bus_t;
endpackage

// [core/adccc_window.sv]
// window comparator: flags a result inside or outside the bounds
// assumes result and bounds are stable in the cycle it is sampled
`timescale 1ns/1ps
`default_nettype none
module adccc_window #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_result,
    input  wire logic [W-1:0] i_lower,
    input  wire logic [W-1:0] i_upper,
    input  wire logic         i_signed,
    output logic              o_match
);
    // signed view flips the top bit so an unsigned compare works
    wire [W-1:0] r = i_signed ? {~i_result[W-1], i_result[W-2:0]} : i_result;
    wire [W-1:0] lo = i_signed ? {~i_lower[W-1], i_lower[W-2:0]} : i_lower;
    wire [W-1:0] up = i_signed ? {~i_upper[W-1], i_upper[W-2:0]} : i_upper;
    wire above = r > lo;
    wire below = r < up;
    assign o_match = (up > lo) ? (above && below) : (above || below);
endmodule
`default_nettype wire

// [core/adccc_core.sv]
// converter control: control/reference registers, start selection,
// track and convert sequencing, done and window flags
// assumes a synchronous register bus, timer overflow pulses and a sar
// that gives its 8-bit result on i_sar_result at end of conversion
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - control register layout, reset to zero
// - software start bit starts conversion, source 000
// - codes 001,010,011 start on timer 0,2,1
// - top bit set starts on pin rising edge
// - low-power mode tracks three clocks then converts, except pin starts, which convert at once
// - each conversion yields an eight-bit result
// - differential mode compares as signed numbers
// - normal bounds: strictly between lower and upper
// - inverted bounds: outside-window detection
module adccc_core
    import adccc_pkg::*;
#(
    parameter int RES_W = 8
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    input  wire adccc_pkg::adccc_bus_t i_bus,
    output logic [7:0]             o_rdata,
    input  wire logic              i_timer0_ovf,
    input  wire logic              i_timer1_ovf,
    input  wire logic              i_timer2_ovf,
    input  wire logic              i_external_start_pin,
    input  wire logic              i_differential,
    input  wire logic [RES_W-1:0]  i_sar_result,
    output logic                   o_tracking,
    output logic                   o_converting,
    output logic                   o_sar_clk_en,
    output logic [7:0]             o_reference_control
);
    import adccc_pkg::*;

    adccc_state_t     state_q, state_d;
    logic [7:0]       ctrl_q, refc_q, lower_q, upper_q;
    logic [RES_W-1:0] result_q;
    logic [3:0]       div_q, cnt_q;
    logic             pin_q, busy_q, track_q, conv_q, sclk_q;
    logic [7:0]       rdata_q;

    wire enable   = ctrl_q[BIT_ENABLE];
    wire low_pwr  = ctrl_q[BIT_TRACK];
    wire [2:0] src = ctrl_q[2:0];
    wire sar_tick = (div_q == SAR_DIV - 4'h1);

    wire wr_ctrl  = i_bus.wr && (i_bus.addr == ADDR_CONVERTER_CONTROL);
    wire wr_ref   = i_bus.wr && (i_bus.addr == ADDR_REFERENCE_CONTROL);
    wire wr_lower = i_bus.wr && (i_bus.addr == ADDR_WINDOW_LOWER);
    wire wr_upper = i_bus.wr && (i_bus.addr == ADDR_WINDOW_UPPER);

    wire pin_rise = i_external_start_pin && !pin_q;
    wire sw_start = wr_ctrl && i_bus.wdata[BIT_START];
    wire trig =
        (src == SRC_SOFTWARE) ? sw_start :
        (src == SRC_TIMER0)   ? i_timer0_ovf :
        (src == SRC_TIMER2)   ? i_timer2_ovf :
        (src == SRC_TIMER1)   ? i_timer1_ovf : pin_rise;
    wire pin_mode  = src[2];
    wire start_ok  = enable && trig && (state_q == ST_IDLE);
    wire conv_end  = (state_q == ST_CONV) && sar_tick
                     && (cnt_q == CONV_CLOCKS - 4'h1);
    wire track_end = (state_q == ST_TRACK) && sar_tick
                     && (cnt_q == TRACK_CLOCKS - 4'h1);

    logic win_match;
    adccc_window #(.W(RES_W)) u_window (
        .i_result (i_sar_result),
        .i_lower  (lower_q),
        .i_upper  (upper_q),
        .i_signed (i_differential),
        .o_match  (win_match)
    );

    // low-power pin mode starts conversion directly: tracking was pin-low
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_ok) begin
                    if (low_pwr && !pin_mode) begin
                        state_d = ST_TRACK;
                    end else begin
                        state_d = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (track_end) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (!enable || conv_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // sar clock divider restarts at each phase change
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q <= 4'h0;
            cnt_q <= 4'h0;
        end else if (state_d != state_q) begin
            div_q <= 4'h0;
            cnt_q <= 4'h0;
        end else if (sar_tick) begin
            div_q <= 4'h0;
            cnt_q <= cnt_q + 4'h1;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            pin_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pin_q   <= i_external_start_pin;
        end
    end

    // hardware set wins over software clear on the flags
    wire done_d = conv_end ||
        (wr_ctrl ? i_bus.wdata[BIT_DONE] : ctrl_q[BIT_DONE]);
    wire win_d = (conv_end && win_match) ||
        (wr_ctrl ? i_bus.wdata[BIT_WINDOW] : ctrl_q[BIT_WINDOW]);
    wire [7:0] ctrl_d = wr_ctrl
        ? {i_bus.wdata[7:6], done_d, 1'b0, win_d, i_bus.wdata[2:0]}
        : {ctrl_q[7:6], done_d, 1'b0, win_d, ctrl_q[2:0]};

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= RST_CONVERTER_CONTROL;
            refc_q <= RST_REFERENCE_CONTROL;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_ref) begin
                refc_q <= i_bus.wdata & REF_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lower_q  <= RST_WINDOW_LOWER;
            upper_q  <= RST_WINDOW_UPPER;
            result_q <= '0;
        end else begin
            if (wr_lower) begin
                lower_q <= i_bus.wdata;
            end
            if (wr_upper) begin
                upper_q <= i_bus.wdata;
            end
            if (conv_end) begin
                result_q <= i_sar_result;
            end
        end
    end

    // start bit reads as busy state
    wire [7:0] ctrl_rd = {ctrl_q[7:5], state_q != ST_IDLE, ctrl_q[3:0]};
    wire [7:0] rd_mux =
        (i_bus.addr == ADDR_CONVERTER_CONTROL) ? ctrl_rd :
        (i_bus.addr == ADDR_REFERENCE_CONTROL) ? refc_q :
        (i_bus.addr == ADDR_WINDOW_LOWER)      ? lower_q :
        (i_bus.addr == ADDR_WINDOW_UPPER)      ? upper_q :
        (i_bus.addr == ADDR_RESULT)            ? result_q : 8'h00;

    // in normal mode tracking runs whenever enabled and not converting
    wire trk_d = enable && ((state_d == ST_TRACK) ||
        (!low_pwr && state_d == ST_IDLE) ||
        (low_pwr && pin_mode && state_d == ST_IDLE
         && !i_external_start_pin));

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 8'h00;
            track_q <= 1'b0;
            conv_q  <= 1'b0;
            sclk_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            rdata_q <= i_bus.rd ? rd_mux : 8'h00;
            track_q <= trk_d;
            conv_q  <= (state_d == ST_CONV);
            sclk_q  <= sar_tick && (state_q != ST_IDLE);
            busy_q  <= (state_d != ST_IDLE);
        end
    end

    assign o_rdata             = rdata_q;
    assign o_tracking          = track_q;
    assign o_converting        = conv_q;
    assign o_sar_clk_en        = sclk_q;
    assign o_reference_control = refc_q;

    // counts cycles spent tracking, for the track length check
    logic [4:0] trk_cyc_q;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            trk_cyc_q <= 5'h00;
        end else if (state_q == ST_TRACK) begin
            trk_cyc_q <= trk_cyc_q + 5'h01;
        end else begin
            trk_cyc_q <= 5'h00;
        end
    end

    a_disabled_idle: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !enable |=> !busy_q) else $error("conversion while disabled");
    a_done_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        conv_end |=> ctrl_q[BIT_DONE]) else $error("done not set");
    a_track_len: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        (state_q == ST_TRACK && state_d == ST_CONV)
        |-> trk_cyc_q == 5'(TRACK_CLOCKS * SAR_DIV - 4'h1))
        else $error("track length wrong");
    a_track_conv: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        track_end |=> state_q == ST_CONV) else $error("no convert");
    a_sw_start: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (enable && !low_pwr && src == SRC_SOFTWARE && sw_start
         && state_q == ST_IDLE) |=> state_q == ST_CONV)
        else $error("sw start lost");
    a_timer_start: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (enable && !low_pwr && src == SRC_TIMER2 && i_timer2_ovf
         && state_q == ST_IDLE) |=> state_q == ST_CONV)
        else $error("timer start lost");
    a_pin_start: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (enable && pin_mode && pin_rise && state_q == ST_IDLE)
        |=> state_q == ST_CONV) else $error("pin start lost");
    a_result_cap: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        conv_end |=> result_q == $past(i_sar_result))
        else $error("result not captured");
    a_window_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (conv_end && win_match) |=> ctrl_q[BIT_WINDOW])
        else $error("window flag not set");
    a_ctrl_reset: assert property (@(posedge i_mclk)
        !i_rstn |-> ctrl_q == 8'h00) else $error("ctrl reset");
endmodule
`default_nettype wire

// [dv/adccc_partner.sv]
// partner: timer overflow pulses and the sar result word
// assumes the bench asks for each overflow one cycle ahead
`timescale 1ns/1ps
`default_nettype none
module adccc_partner (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic [2:0] i_fire,
    input  wire logic [7:0] i_value,
    output logic            o_timer0_ovf,
    output logic            o_timer1_ovf,
    output logic            o_timer2_ovf,
    output logic [7:0]      o_sar_result
);
    // overflows are single-cycle pulses, result held steady
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            {o_timer2_ovf, o_timer1_ovf, o_timer0_ovf} <= 3'h0;
            o_sar_result <= 8'h00;
        end else begin
            {o_timer2_ovf, o_timer1_ovf, o_timer0_ovf} <= i_fire;
            o_sar_result <= i_value;
        end
    end
endmodule
`default_nettype wire

// [dv/adccc_core_test.sv]
// testbench: register reads, every start source, window flags
// assumes the partner model supplies timers and the sar result
`timescale 1ns/1ps
`default_nettype none
module adccc_core_test;
    import adccc_pkg::*;
    logic       i_mclk;
    logic       i_rstn;
    adccc_bus_t bus;
    logic [7:0] o_rdata, o_reference_control, sar, val, r;
    logic       o_tracking, o_converting, sar_en, pin, diff, rd_pend;
    logic       t0, t1, t2;
    logic [2:0] fire;
    logic [7:0] expq[$];
    logic [7:0] tbl[4] = '{8'h05, 8'h80, 8'h10, 8'hFF};
    int         num_errors, tests_run;

    adccc_core uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(bus),
        .o_rdata(o_rdata), .i_timer0_ovf(t0), .i_timer1_ovf(t1),
        .i_timer2_ovf(t2), .i_external_start_pin(pin),
        .i_differential(diff), .i_sar_result(sar),
        .o_tracking(o_tracking), .o_converting(o_converting),
        .o_sar_clk_en(sar_en), .o_reference_control(o_reference_control));
    adccc_partner far (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_fire(fire),
        .i_value(val), .o_timer0_ovf(t0), .o_timer1_ovf(t1),
        .o_timer2_ovf(t2), .o_sar_result(sar));

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic winf(input logic [7:0] v, lo, hi,
                                  input logic s);
        logic signed [8:0] a, l, h;
        a = {s & v[7], v};
        l = {s & lo[7], lo};
        h = {s & hi[7], hi};
        return (h > l) ? (a > l && a < h) : (a < h || a > l);
    endfunction

    task automatic chk8(input logic [7:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk1(input logic got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %b", $time, m, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge i_mclk);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge i_mclk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        @(posedge i_mclk);
        bus <= {1'b0, 1'b1, a, 8'h00};
        expq.push_back(e);
        @(posedge i_mclk);
        bus.rd <= 1'b0;
    endtask

    // read data shows one cycle after the read strobe is taken
    always @(posedge i_mclk) begin
        if (rd_pend && expq.size() > 0)
            chk8(o_rdata, expq.pop_front(), "read");
        rd_pend <= bus.rd;
    end

    task automatic conv(input logic tm, input logic [2:0] src,
                        input logic [7:0] v, lo, hi);
        logic [7:0] c;
        int n, tr, ck;
        c = {1'b1, tm, 3'b000, src};
        val <= v;
        n = 0;
        tr = 0;
        ck = 0;
        wr(ADDR_WINDOW_LOWER, lo);
        wr(ADDR_WINDOW_UPPER, hi);
        wr(ADDR_CONVERTER_CONTROL, c);
        if (src == SRC_SOFTWARE) begin
            wr(ADDR_CONVERTER_CONTROL, c | 8'h10);
        end else if (src[2]) begin
            @(posedge i_mclk) pin <= 1'b0;
            repeat (6) @(posedge i_mclk);
            chk1(o_tracking, 1'b1, "pin low tracks");
            pin <= 1'b1;
        end else begin
            @(posedge i_mclk) fire <= {src == SRC_TIMER2,
                src == SRC_TIMER1, src == SRC_TIMER0};
            @(posedge i_mclk) fire <= 3'h0;
        end
        while (o_converting !== 1'b1 && n < 60) begin
            @(posedge i_mclk);
            n++;
            tr += (o_tracking === 1'b1);
            ck += (sar_en === 1'b1);
        end
        chk1(o_converting, 1'b1, "start");
        if (tm && !src[2])
            chk8(tr[7:0], {4'h0, TRACK_CLOCKS} * {4'h0, SAR_DIV}, "track span");
        while (o_converting !== 1'b0 && n < 400) begin
            @(posedge i_mclk);
            n++;
            ck += (sar_en === 1'b1);
        end
        chk8(ck[7:0], {4'h0, (tm && !src[2]) ? TRACK_CLOCKS + CONV_CLOCKS
             : CONV_CLOCKS}, "sar clocks");
        c = c | 8'h20 | {4'h0, winf(v, lo, hi, diff), 3'h0};
        rd(ADDR_CONVERTER_CONTROL, c);
        rd(ADDR_RESULT, v);
        repeat (5) @(posedge i_mclk);
        rd(ADDR_CONVERTER_CONTROL, c);
        $display("test conversion src %0d mode %0d done", src, tm);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        summarize;
    end

    initial begin
        i_rstn = 1'b1;
        bus = '0;
        pin = 1'b1;
        diff = 1'b0;
        fire = 3'h0;
        val = 8'h00;
        rd_pend = 1'b0;
        num_errors = 0;
        tests_run = 0;
        r = 8'd87;
        // assert reset off time zero so every flop sees the edge
        #1;
        i_rstn = 1'b0;
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(ADDR_CONVERTER_CONTROL, RST_CONVERTER_CONTROL);
        rd(ADDR_REFERENCE_CONTROL, RST_REFERENCE_CONTROL);
        rd(ADDR_WINDOW_LOWER, RST_WINDOW_LOWER);
        rd(ADDR_WINDOW_UPPER, RST_WINDOW_UPPER);
        rd(8'h80, 8'h00);
        wr(ADDR_REFERENCE_CONTROL, 8'hFF);
        rd(ADDR_REFERENCE_CONTROL, REF_WRITE_MASK);
        chk8(o_reference_control, REF_WRITE_MASK, "ref out");
        $display("test registers done");
        for (int m = 0; m < 12; m++) begin
            r = lfsr(r);
            conv(m[0], m[3:1], r, 8'h20, 8'hD0);
        end
        // input configuration change, then settle before converting
        diff <= 1'b1;
        repeat (20) @(posedge i_mclk);
        for (int k = 0; k < 8; k++)
            conv(1'b0, SRC_SOFTWARE, tbl[k % 4], k < 4 ? 8'hFF : 8'h10,
                 k < 4 ? 8'h10 : 8'hFF);
        diff <= 1'b0;
        conv(1'b0, SRC_SOFTWARE, 8'h10, 8'hD0, 8'h20);
        wr(ADDR_CONVERTER_CONTROL, 8'h00);
        wr(ADDR_CONVERTER_CONTROL, 8'h10);
        repeat (2) @(posedge i_mclk);
        chk1(o_converting, 1'b0, "disabled start");
        repeat (48) @(posedge i_mclk);
        chk1(o_converting, 1'b0, "disabled");
        rd(ADDR_CONVERTER_CONTROL, 8'h00);
        repeat (5) @(posedge i_mclk);
        $display("test disabled done");
        summarize;
    end
endmodule
`default_nettype wire
